/* File: dtms_pkg.sv */
// package: register map, field positions, reset values and mode types of the timer pair mode select
package dtms_pkg;
  // register indices; byte address is four times the index
  localparam logic [19:0] DTMS_PMR_IDX = 20'hf0265;
  localparam logic [19:0] DTMS_FCR_IDX = 20'hf0266;
  localparam logic [19:0] DTMS_RUN_IDX = 20'hf0270;
  localparam logic [19:0] DTMS_STAT_IDX = 20'hf0271;
  localparam logic [31:0] DTMS_PMR_ADDR = {10'h000, DTMS_PMR_IDX, 2'b00};
  localparam logic [31:0] DTMS_FCR_ADDR = {10'h000, DTMS_FCR_IDX, 2'b00};
  localparam logic [31:0] DTMS_RUN_ADDR = {10'h000, DTMS_RUN_IDX, 2'b00};
  localparam logic [31:0] DTMS_STAT_ADDR = {10'h000, DTMS_STAT_IDX, 2'b00};
  // values after reset
  localparam logic [7:0] DTMS_PMR_RESET = 8'h00;
  localparam logic [7:0] DTMS_FCR_RESET = 8'h80;
  localparam logic [7:0] DTMS_RUN_RESET = 8'h00;
  // writable bits of each register; all others read 0
  localparam logic [7:0] DTMS_PMR_MASK = 8'h77;
  localparam logic [7:0] DTMS_FCR_MASK = 8'hcf;
  localparam logic [7:0] DTMS_RUN_MASK = 8'h03;
  // pin select field positions
  localparam int DTMS_PMR_CH0_LSB = 0;
  localparam int DTMS_PMR_CH1_LSB = 4;
  // function control field positions
  localparam int DTMS_FCR_THREE_PHASE_N = 7;
  localparam int DTMS_FCR_EXT_CLK = 6;
  localparam int DTMS_FCR_CPHASE_POL = 3;
  localparam int DTMS_FCR_PHASE_POL = 2;
  localparam int DTMS_FCR_COMBO_LSB = 0;
  // count run field positions
  localparam int DTMS_RUN_CH0 = 0;
  localparam int DTMS_RUN_CH1 = 1;
  // status field positions
  localparam int DTMS_STAT_EXT_CLK = 3;
  localparam int DTMS_STAT_COMBO_ERR = 4;
  // combination mode codes
  localparam logic [1:0] DTMS_COMBO_TIMER = 2'b00;
  localparam logic [1:0] DTMS_COMBO_RESET_SYNC = 2'b01;
  localparam logic [1:0] DTMS_COMBO_COMPL_UNDERFLOW = 2'b10;
  localparam logic [1:0] DTMS_COMBO_COMPL_MATCH = 2'b11;
  // bus responses
  localparam logic [1:0] DTMS_RESP_OKAY = 2'b00;
  localparam logic [1:0] DTMS_RESP_SLVERR = 2'b10;
  // operating modes of the pair
  typedef enum logic [2:0] {
    DTMS_MODE_TIMER,
    DTMS_MODE_THREE_PHASE,
    DTMS_MODE_RESET_SYNC,
    DTMS_MODE_COMPL_UNDERFLOW,
    DTMS_MODE_COMPL_MATCH
  } dtms_mode_t;
endpackage

/* File: dtms_cfg_if.sv */
// interface: register contents out to the mode decoder and decoded controls back
`timescale 1ns/1ps
interface dtms_cfg_if;
  import dtms_pkg::*;
  logic [7:0] pinSel;
  logic [7:0] funcCtl;
  dtms_mode_t mode;
  logic [5:0] pinPwm;
  logic extClkEn;
  logic polarityLive;
  logic phaseActiveHigh;
  logic cphaseActiveHigh;
  logic complMode;
  logic xferOnUnderflow;
  modport ctl (output pinSel, output funcCtl, input mode, input pinPwm, input extClkEn,
    input polarityLive, input phaseActiveHigh, input cphaseActiveHigh, input complMode,
    input xferOnUnderflow);
  modport dec (input pinSel, input funcCtl, output mode, output pinPwm, output extClkEn,
    output polarityLive, output phaseActiveHigh, output cphaseActiveHigh, output complMode,
    output xferOnUnderflow);
endinterface

/* File: dtms_mode_decode.sv */
// module: decodes combination mode, pin functions, clock enable and output polarity
`timescale 1ns/1ps
module dtms_mode_decode (
  dtms_cfg_if.dec cfg // register contents in, decoded controls out
);
  import dtms_pkg::*;

  logic [1:0] combo;
  logic pairPwm;

  ////////////////////////////////////////////////////////////////////////////////
  // combination mode decode
  assign combo = cfg.funcCtl[DTMS_FCR_COMBO_LSB +: 2];

  always_comb begin
    case (combo)
      DTMS_COMBO_RESET_SYNC: cfg.mode = DTMS_MODE_RESET_SYNC;
      DTMS_COMBO_COMPL_UNDERFLOW: cfg.mode = DTMS_MODE_COMPL_UNDERFLOW;
      DTMS_COMBO_COMPL_MATCH: cfg.mode = DTMS_MODE_COMPL_MATCH;
      default: begin
        // three-phase select only counts while combo is 00
        if (cfg.funcCtl[DTMS_FCR_THREE_PHASE_N]) begin
          cfg.mode = DTMS_MODE_TIMER;
        end else begin
          cfg.mode = DTMS_MODE_THREE_PHASE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // derived controls
  assign pairPwm = (combo != DTMS_COMBO_TIMER);
  assign cfg.complMode = (cfg.mode == DTMS_MODE_COMPL_UNDERFLOW) ||
    (cfg.mode == DTMS_MODE_COMPL_MATCH);
  assign cfg.xferOnUnderflow = (cfg.mode == DTMS_MODE_COMPL_UNDERFLOW);
  // pin selects are overridden by any nonzero combination mode
  assign cfg.pinPwm = pairPwm ? 6'h00 :
    {cfg.pinSel[DTMS_PMR_CH1_LSB +: 3], cfg.pinSel[DTMS_PMR_CH0_LSB +: 3]};
  // external clock is held off in three-phase mode as a safety measure
  assign cfg.extClkEn = cfg.funcCtl[DTMS_FCR_EXT_CLK] &&
    (cfg.mode != DTMS_MODE_THREE_PHASE);
  // polarity only acts in reset-synchronous and complementary modes
  assign cfg.polarityLive = pairPwm;
  assign cfg.phaseActiveHigh = pairPwm && cfg.funcCtl[DTMS_FCR_PHASE_POL];
  assign cfg.cphaseActiveHigh = pairPwm && cfg.funcCtl[DTMS_FCR_CPHASE_POL];
endmodule

/* File: dtms_top.sv */
// module: register file and AXI4-Lite slave for the timer pair mode select
//
// Summary of operation
// - each B, C, D pin select bit: 1 runs PWM, 0 runs capture/compare
// - with combo 00, three-phase select 0 picks three-phase, 1 picks timer
// - three-phase select only matters while combo field is 00
// - external clock select 1 enables the external count clock except in three-phase mode, 0 disables
// - counter-phase polarity: 0 high initial low active, 1 the reverse, only in reset-sync or complementary
// - phase polarity same encoding, only in reset-sync or complementary
// - combo 01 selects reset-synchronous PWM mode
// - combo 10 selects complementary PWM, transfer on channel 1 underflow
// - combo 11 selects complementary PWM, transfer on channel 0 match A
// - nonzero combo forces pair PWM mode and ignores pin select bits
// - each channel run flag: write 1 starts, write 0 stops
`timescale 1ns/1ps
module dtms_top (
  input wire logic clk, // 20 MHz clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic extClkPin, // external count clock pin, asynchronous
  input wire logic ch1Underflow, // channel 1 counter underflow pulse
  input wire logic ch0MatchA, // channel 0 counter equals general A pulse
  output logic [5:0] pinPwmSel, // per pin PWM function, {ch1 D C B, ch0 D C B}
  output dtms_pkg::dtms_mode_t pairMode, // decoded operating mode
  output logic extCountEdge, // one-cycle pulse per enabled external clock rise
  output logic phaseInitHigh, // normal-phase initial level high
  output logic phaseActiveHigh, // normal-phase active level high
  output logic cphaseInitHigh, // counter-phase initial level high
  output logic cphaseActiveHigh, // counter-phase active level high
  output logic bufferTransfer, // one-cycle pulse: copy buffers to general regs
  output logic ch0CountRun, // channel 0 counter running
  output logic ch1CountRun // channel 1 counter running
);
  import dtms_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0] pinSelReg;
  logic [7:0] funcCtlReg;
  logic [7:0] runReg;
  logic comboErr;
  logic awHeld;
  logic wHeld;
  logic [31:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic doWrite;
  logic lowLane;
  logic hitPmr;
  logic hitFcr;
  logic hitRun;
  logic hitStat;
  logic wrMapped;
  logic [7:0] wrByte;
  logic comboChange;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [7:0] statByte;
  logic extSync1;
  logic extSync2;
  logic extSync3;
  logic xferEvent;

  dtms_cfg_if cfg ();

  ////////////////////////////////////////////////////////////////////////////////
  // mode decoder
  assign cfg.pinSel = pinSelReg;
  assign cfg.funcCtl = funcCtlReg;

  dtms_mode_decode u_decode (
    .cfg (cfg)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // write channel handshakes: address and data taken in either order
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  // write address holding
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld <= 1'b0;
      awAddrQ <= 32'h0000_0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddrQ <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end
  end

  // write data holding
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wHeld <= 1'b0;
      wDataQ <= 32'h0000_0000;
      wStrbQ <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wDataQ <= s_axi_wdata;
      wStrbQ <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write address decode
  always_comb begin
    hitPmr = 1'b0;
    hitFcr = 1'b0;
    hitRun = 1'b0;
    hitStat = 1'b0;
    if (awAddrQ[31:2] == DTMS_PMR_ADDR[31:2]) begin
      hitPmr = 1'b1;
    end else if (awAddrQ[31:2] == DTMS_FCR_ADDR[31:2]) begin
      hitFcr = 1'b1;
    end else if (awAddrQ[31:2] == DTMS_RUN_ADDR[31:2]) begin
      hitRun = 1'b1;
    end else if (awAddrQ[31:2] == DTMS_STAT_ADDR[31:2]) begin
      hitStat = 1'b1;
    end
  end

  assign wrMapped = hitPmr || hitFcr || hitRun || hitStat;
  // only the low byte lane carries register bits
  assign lowLane = doWrite && wStrbQ[0];
  assign wrByte = wDataQ[7:0];
  assign comboChange = (wrByte[DTMS_FCR_COMBO_LSB +: 2] !=
    funcCtlReg[DTMS_FCR_COMBO_LSB +: 2]);

  // write response, held until the master takes it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= DTMS_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrMapped ? DTMS_RESP_OKAY : DTMS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin function select register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinSelReg <= DTMS_PMR_RESET;
    end else if (lowLane && hitPmr) begin
      pinSelReg <= wrByte & DTMS_PMR_MASK;
    end
  end

  // function control register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      funcCtlReg <= DTMS_FCR_RESET;
    end else if (lowLane && hitFcr) begin
      funcCtlReg <= wrByte & DTMS_FCR_MASK;
    end
  end

  // counter run flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      runReg <= DTMS_RUN_RESET;
    end else if (lowLane && hitRun) begin
      runReg <= wrByte & DTMS_RUN_MASK;
    end
  end

  // sticky flag: combo changed while a counter ran; set wins over clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      comboErr <= 1'b0;
    end else if (lowLane && hitFcr && comboChange && (runReg[1:0] != 2'b00)) begin
      comboErr <= 1'b1;
    end else if (lowLane && hitStat && wrByte[DTMS_STAT_COMBO_ERR]) begin
      comboErr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path: one read under way, answered the cycle after the address
  assign s_axi_arready = !s_axi_rvalid;
  assign statByte = {3'b000, comboErr, cfg.extClkEn, pairMode};

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = DTMS_RESP_OKAY;
    if (s_axi_araddr[31:2] == DTMS_PMR_ADDR[31:2]) begin
      next_rdata = {24'h000000, pinSelReg};
    end else if (s_axi_araddr[31:2] == DTMS_FCR_ADDR[31:2]) begin
      next_rdata = {24'h000000, funcCtlReg};
    end else if (s_axi_araddr[31:2] == DTMS_RUN_ADDR[31:2]) begin
      next_rdata = {24'h000000, runReg};
    end else if (s_axi_araddr[31:2] == DTMS_STAT_ADDR[31:2]) begin
      next_rdata = {24'h000000, statByte};
    end else begin
      next_rresp = DTMS_RESP_SLVERR;
    end
  end

  // read data register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= DTMS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // external clock pin: two-stage synchroniser, edge taken after it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      extSync1 <= 1'b0;
      extSync2 <= 1'b0;
      extSync3 <= 1'b0;
    end else begin
      extSync1 <= extClkPin;
      extSync2 <= extSync1;
      extSync3 <= extSync2;
    end
  end

  // rising edges pass only while the external clock is enabled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      extCountEdge <= 1'b0;
    end else begin
      extCountEdge <= cfg.extClkEn && extSync2 && !extSync3;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // buffer-to-general transfer timing in complementary mode
  assign xferEvent = cfg.xferOnUnderflow ? ch1Underflow : ch0MatchA;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bufferTransfer <= 1'b0;
    end else begin
      bufferTransfer <= cfg.complMode && xferEvent;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // decoded controls registered onto the outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinPwmSel <= 6'h00;
      pairMode <= DTMS_MODE_TIMER;
    end else begin
      pinPwmSel <= cfg.pinPwm;
      pairMode <= cfg.mode;
    end
  end

  // output levels: 0 gives high initial / low active, 1 the reverse in reset-sync or complementary modes only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phaseInitHigh <= 1'b1;
      phaseActiveHigh <= 1'b0;
      cphaseInitHigh <= 1'b1;
      cphaseActiveHigh <= 1'b0;
    end else begin
      phaseInitHigh <= !cfg.phaseActiveHigh;
      phaseActiveHigh <= cfg.phaseActiveHigh;
      cphaseInitHigh <= !cfg.cphaseActiveHigh;
      cphaseActiveHigh <= cfg.cphaseActiveHigh;
    end
  end

  // counter run outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ch0CountRun <= 1'b0;
      ch1CountRun <= 1'b0;
    end else begin
      ch0CountRun <= runReg[DTMS_RUN_CH0];
      ch1CountRun <= runReg[DTMS_RUN_CH1];
    end
  end
endmodule

/* File: dtms_top_monitor.sv */
// checker: port-level assertions for the timer pair mode select
`timescale 1ns/1ps
module dtms_monitor (
  input wire logic clk, // clock
  input wire logic arst_n, // async reset, active low
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic ch1Underflow, // underflow pulse
  input wire logic ch0MatchA, // match pulse
  input wire logic [5:0] pinPwmSel, // pin functions
  input wire dtms_pkg::dtms_mode_t pairMode, // decoded mode
  input wire logic phaseInitHigh, // phase initial level
  input wire logic phaseActiveHigh, // phase active level
  input wire logic cphaseInitHigh, // counter-phase initial level
  input wire logic cphaseActiveHigh, // counter-phase active level
  input wire logic bufferTransfer, // transfer pulse
  input wire logic extCountEdge, // external count pulse
  input wire logic ch0CountRun, // channel 0 running
  input wire logic ch1CountRun // channel 1 running
);
  import dtms_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic wrBoth;
  logic pairMode01;
  // address and data taken at one edge with the low byte enabled
  assign wrBoth = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
  assign pairMode01 = pairMode inside {DTMS_MODE_TIMER, DTMS_MODE_THREE_PHASE};
  ////////////////////////////////////////////////////////////////////////////////////////////
  pin_mode_excl_a: assert property (pinPwmSel != 6'h00 |-> pairMode01)
    else $error("pin select live in a pair mode");
  phase_pol_mode_a: assert property (phaseActiveHigh |-> !pairMode01)
    else $error("phase polarity live outside pair modes");
  phase_init_inv_a: assert property (phaseInitHigh != phaseActiveHigh)
    else $error("phase initial and active levels equal");
  cphase_init_inv_a: assert property (cphaseInitHigh != cphaseActiveHigh)
    else $error("counter-phase initial and active levels equal");
  xfer_underflow_a: assert property (ch1Underflow && pairMode == DTMS_MODE_COMPL_UNDERFLOW
    |=> bufferTransfer)
    else $error("no transfer after underflow");
  xfer_match_a: assert property (ch0MatchA && pairMode == DTMS_MODE_COMPL_MATCH
    |=> bufferTransfer)
    else $error("no transfer after match");
  xfer_cause_a: assert property (bufferTransfer |->
    $past(ch1Underflow) || $past(ch0MatchA))
    else $error("transfer without a cause");
  run_write_a: assert property (wrBoth && s_axi_awaddr == DTMS_RUN_ADDR |-> ##3
    {ch1CountRun, ch0CountRun} == $past(s_axi_wdata[1:0], 3))
    else $error("run flags do not follow write");
  pin_write_a: assert property (wrBoth && s_axi_awaddr == DTMS_PMR_ADDR |-> ##3
    pinPwmSel == (pairMode01 ? {$past(s_axi_wdata[6:4], 3), $past(s_axi_wdata[2:0], 3)} : 6'h00))
    else $error("pin select does not follow write");
  // main scenarios reached
  cov_match_c: cover property (pairMode == DTMS_MODE_COMPL_MATCH && bufferTransfer);
  cov_under_c: cover property (pairMode == DTMS_MODE_COMPL_UNDERFLOW && bufferTransfer);
  cov_ext_c: cover property (extCountEdge);
endmodule
bind dtms_top dtms_monitor i_monitor (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .ch1Underflow(ch1Underflow), .ch0MatchA(ch0MatchA), .pinPwmSel(pinPwmSel), .pairMode(pairMode),
  .phaseInitHigh(phaseInitHigh), .phaseActiveHigh(phaseActiveHigh),
  .cphaseInitHigh(cphaseInitHigh), .cphaseActiveHigh(cphaseActiveHigh),
  .bufferTransfer(bufferTransfer), .extCountEdge(extCountEdge), .ch0CountRun(ch0CountRun),
  .ch1CountRun(ch1CountRun));

/* File: dtms_tb_top.sv */
// testbench: register access and decoded outputs of the timer pair mode select
`timescale 1ns/1ps
module dtms_tb_top;
  import dtms_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [31:0] awAddr = 32'h0, wData = 32'h0, arAddr = 32'h0, rData;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid, extCountEdge, bufferTransfer;
  logic [1:0] bResp, rResp;
  logic extClkPin = 1'b0, ch1Underflow = 1'b0, ch0MatchA = 1'b0;
  logic [5:0] pinPwmSel;
  dtms_mode_t pairMode;
  logic phaseInitHigh, phaseActiveHigh, cphaseInitHigh, cphaseActiveHigh, ch0Run, ch1Run;
  int failures = 0, nCompared = 0, cycles = 0, edges = 0, n0;
  // function control values with expected mode and active levels {phase, counter-phase}
  logic [7:0] fd[7] = '{8'h80, 8'h00, 8'h8c, 8'h01, 8'h8d, 8'h8a, 8'h87};
  dtms_mode_t fm[7] = '{DTMS_MODE_TIMER, DTMS_MODE_THREE_PHASE, DTMS_MODE_TIMER,
    DTMS_MODE_RESET_SYNC, DTMS_MODE_RESET_SYNC, DTMS_MODE_COMPL_UNDERFLOW, DTMS_MODE_COMPL_MATCH};
  logic [1:0] fa[7] = '{2'b00, 2'b00, 2'b00, 2'b00, 2'b11, 2'b01, 2'b10};
  logic [7:0] ed[3] = '{8'hc0, 8'h80, 8'hc1};
  logic [31:0] runVal[3] = '{32'h1, 32'h2, 32'h0};
  dtms_top i_dut (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .extClkPin(extClkPin),
    .ch1Underflow(ch1Underflow), .ch0MatchA(ch0MatchA), .pinPwmSel(pinPwmSel),
    .pairMode(pairMode), .extCountEdge(extCountEdge), .phaseInitHigh(phaseInitHigh),
    .phaseActiveHigh(phaseActiveHigh), .cphaseInitHigh(cphaseInitHigh),
    .cphaseActiveHigh(cphaseActiveHigh), .bufferTransfer(bufferTransfer),
    .ch0CountRun(ch0Run), .ch1CountRun(ch1Run));
  ////////////////////////////////////////////////////////////////////////////////////////////
  // clock, hang limit and external pulse counter
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (extCountEdge === 1'b1) edges++;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////////////////
  // compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", nCompared, failures);
    if (failures == 0 && nCompared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // bus write: address and data offered together, response checked
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aOk, wOk, aTake, wTake, bOk;
    aOk = 1'b0;
    wOk = 1'b0;
    bOk = 1'b0;
    @(posedge clk);
    awAddr <= a;
    awValid <= 1'b1;
    wData <= d;
    wValid <= 1'b1;
    bReady <= 1'b1;
    while (!(aOk && wOk)) begin
      @(negedge clk);
      aTake = awValid && awReady;
      wTake = wValid && wReady;
      @(posedge clk);
      if (aTake) begin
        awValid <= 1'b0;
        aOk = 1'b1;
      end
      if (wTake) begin
        wValid <= 1'b0;
        wOk = 1'b1;
      end
    end
    while (!bOk) begin
      @(negedge clk);
      bOk = bValid;
    end
    chk({30'h0, bResp}, {30'h0, er});
    @(posedge clk);
    bReady <= 1'b0;
  endtask
  // bus read with expected data and response
  task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic aOk, rOk;
    aOk = 1'b0;
    rOk = 1'b0;
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    while (!aOk) begin
      @(negedge clk);
      aOk = arReady;
      @(posedge clk);
    end
    arValid <= 1'b0;
    while (!rOk) begin
      @(negedge clk);
      rOk = rValid;
    end
    chk(rData, ed);
    chk({30'h0, rResp}, {30'h0, er});
    @(posedge clk);
    rReady <= 1'b0;
  endtask
  // one-cycle event pulse, outputs looked at in the cycle after
  task automatic pulse(input bit under);
    @(posedge clk);
    ch1Underflow <= under;
    ch0MatchA <= !under;
    @(posedge clk);
    ch1Underflow <= 1'b0;
    ch0MatchA <= 1'b0;
    @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk({29'h0, pairMode}, {29'h0, DTMS_MODE_TIMER});
    chk({phaseInitHigh, cphaseInitHigh, phaseActiveHigh, cphaseActiveHigh}, 4'hc);
    rd(DTMS_PMR_ADDR, {24'h0, DTMS_PMR_RESET}, DTMS_RESP_OKAY);
    rd(DTMS_FCR_ADDR, {24'h0, DTMS_FCR_RESET}, DTMS_RESP_OKAY);
    wr(DTMS_PMR_ADDR, 32'hffffffff, DTMS_RESP_OKAY);
    rd(DTMS_PMR_ADDR, 32'h77, DTMS_RESP_OKAY);
    repeat (2) @(negedge clk);
    chk({26'h0, pinPwmSel}, 32'h3f);
    wr(DTMS_PMR_ADDR, 32'h25, DTMS_RESP_OKAY);
    repeat (2) @(negedge clk);
    chk({26'h0, pinPwmSel}, 32'h15);
    wr(DTMS_FCR_ADDR, 32'hff, DTMS_RESP_OKAY);
    rd(DTMS_FCR_ADDR, 32'hcf, DTMS_RESP_OKAY);
    // every mode, both polarities; counters stay stopped throughout
    for (int i = 0; i < 7; i++) begin
      wr(DTMS_FCR_ADDR, {24'h0, fd[i]}, DTMS_RESP_OKAY);
      repeat (2) @(negedge clk);
      chk({29'h0, pairMode}, {29'h0, fm[i]});
      chk({phaseActiveHigh, cphaseActiveHigh, phaseInitHigh, cphaseInitHigh},
        {fa[i], ~fa[i]});
      chk({26'h0, pinPwmSel}, (fd[i][1:0] == 2'b00) ? 32'h15 : 32'h0);
    end
    // external clock only counts when enabled; tried in timer and reset-synchronous modes
    for (int i = 0; i < 3; i++) begin
      wr(DTMS_FCR_ADDR, {24'h0, ed[i]}, DTMS_RESP_OKAY);
      repeat (4) @(posedge clk);
      n0 = edges;
      extClkPin <= 1'b1;
      repeat (4) @(posedge clk);
      extClkPin <= 1'b0;
      repeat (6) @(negedge clk);
      chk(edges - n0, (i == 1) ? 32'h0 : 32'h1);
    end
    // status shows the live clock enable and the reset-synchronous mode
    rd(DTMS_STAT_ADDR, {28'h0, 1'b1, DTMS_MODE_RESET_SYNC}, DTMS_RESP_OKAY);
    // buffer transfer timing in both complementary modes
    for (int c = 2; c < 4; c++) begin
      wr(DTMS_FCR_ADDR, 32'h80 | c, DTMS_RESP_OKAY);
      repeat (2) @(negedge clk);
      pulse(1'b1);
      chk({31'h0, bufferTransfer}, (c == 2) ? 32'h1 : 32'h0);
      pulse(1'b0);
      chk({31'h0, bufferTransfer}, (c == 3) ? 32'h1 : 32'h0);
    end
    for (int i = 0; i < 3; i++) begin
      wr(DTMS_RUN_ADDR, runVal[i], DTMS_RESP_OKAY);
      repeat (2) @(negedge clk);
      chk({30'h0, ch1Run, ch0Run}, runVal[i]);
    end
    wr(32'h10, 32'h1, DTMS_RESP_SLVERR);
    rd(32'h10, 32'h0, DTMS_RESP_SLVERR);
    finish_test();
  end
endmodule
